// >>> logic/csc_top.v
// clock generation, oscillator control and stop / wait sequencing
`include "csc_defs.vh"

// Behaviour
// - low-speed mode system clock is sub-clock divided by two.
// - after reset or stop exit, variant picks mode from osc select pin.
// - osc select pin sampled at reset release and at stop instruction.
// - mode bit5 main osc, bit4 sub osc, second mode bit0 on-chip osc.
// - low-speed stops on-chip osc on rom variant; flash needs stop bit.
// - main osc may be stopped in on-chip or low-speed mode.
// - stop halts system clock high and stops main and sub oscillators.
// - stop reloads timer 1 and 2 from latches as wait count.
// - in stop timer 1 cascades into timer 2; divider select untouched.
// - entering stop clears timer 12 mode bits 0 to 5.
// - interrupt in stop restarts oscillator chosen by osc select pin.
// - stop exit forces mode bits 3,5,6,7 and second bit0 by pin.
// - flash stop exit: on-chip on, bit3 zero, bits5-7 one, bit0 zero.
// - system clock withheld after stop wake until timer 2 underflows.
// - wait stops only system clock high; oscillators unchanged.
// - interrupt in wait restarts system clock immediately.
// - on-chip mode system clock is on-chip osc divided by 32.
// - main mode system clock is main input divided by 2, 4 or 8.
module csc_top #(
	parameter FLASH_VARIANT = 0,
	parameter DIV_W = 6
) (
	input wire sys_clk_i,
	input wire srst_i,
	input wire ce_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire osc_select_pin_i,
	input wire main_osc_tick_i,
	input wire sub_osc_tick_i,
	input wire onchip_osc_tick_i,
	input wire irq_i,
	output reg [7:0] rdata_o,
	output reg sys_clk_phase_o,
	output reg sys_clk_en_o,
	output reg main_osc_en_o,
	output reg sub_osc_en_o,
	output reg onchip_osc_en_o,
	output reg [1:0] power_state_o
);
	localparam ST_RUN = `CSC_ST_RUN;
	localparam ST_WAIT = `CSC_ST_WAIT;
	localparam ST_STOP = `CSC_ST_STOP;
	localparam ST_SETTLE = `CSC_ST_SETTLE;

	reg [7:0] cpu_mode_reg;
	reg [7:0] cpu_mode_reg_second;
	reg [7:0] t1_latch;
	reg [7:0] t2_latch;
	reg [7:0] t12_mode;
	reg [7:0] t12_divsel;
	reg [1:0] state;
	reg [1:0] next_state;
	reg sel_high;
	reg init_pending;
	reg [DIV_W-1:0] ratio;
	reg src_tick;
	wire div_tick;
	wire div_phase;
	wire [7:0] t1_val;
	wire [7:0] t2_val;
	wire t2_underflow;
	wire stop_instruction;
	wire wait_instruction;
	wire stab_load;

	// register writes to the command register act as cpu instructions
	assign stop_instruction = wr_i && (addr_i == `CSC_ADDR_CMD) &&
		wdata_i[`CSC_CMD_STOP_BIT] && (state == ST_RUN);
	assign wait_instruction = wr_i && (addr_i == `CSC_ADDR_CMD) &&
		wdata_i[`CSC_CMD_WAIT_BIT] && !wdata_i[`CSC_CMD_STOP_BIT] &&
		(state == ST_RUN);
	assign stab_load = stop_instruction;

	// forced mode image chosen by variant and pin level
	function [7:0] forced_mode;
		input high;
		input [7:0] cur;
		begin
			if (FLASH_VARIANT != 0 || !high)
				forced_mode = (cur & `CSC_MODE_KEEP_MASK) | `CSC_MODE_RST_LO;
			else
				forced_mode = (cur & `CSC_MODE_KEEP_MASK) | `CSC_MODE_RST_HI;
		end
	endfunction

	// forced on-chip stop bit: only a high pin on the rom variant stops it,
	// so the main oscillator is the only one restarted in that case
	function onchip_stop;
		input high;
		begin
			onchip_stop = (FLASH_VARIANT == 0) && high;
		end
	endfunction

	// clock select field decoded into the divide ratio and its source
	always @* begin
		case (cpu_mode_reg[`CSC_MODE_CLKSEL_HI:`CSC_MODE_CLKSEL_LO])
			`CSC_CLK_LOWSPEED: begin
				ratio = `CSC_DIV_SUB;
				src_tick = sub_osc_tick_i;
			end
			`CSC_CLK_ONCHIP: begin
				ratio = `CSC_DIV_ONCHIP;
				src_tick = onchip_osc_tick_i;
			end
			`CSC_CLK_DIV8: begin
				ratio = `CSC_DIV_MAIN8;
				src_tick = main_osc_tick_i;
			end
			default: begin
				ratio = cpu_mode_reg[`CSC_MODE_B3] ? `CSC_DIV_MAIN4 : `CSC_DIV_MAIN2;
				src_tick = main_osc_tick_i;
			end
		endcase
	end

	csc_clk_div #(
		.W(DIV_W)
	) u_div (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.src_tick_i(src_tick),
		.ratio_i(ratio),
		.tick_o(div_tick),
		.phase_o(div_phase)
	);

	// cascade runs on the divided source only while stopped or settling
	csc_stab_timer u_stab (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.load_i(stab_load),
		.run_i(state == ST_STOP || state == ST_SETTLE),
		.src_tick_i(div_tick),
		.t1_latch_i(t1_latch),
		.t2_latch_i(t2_latch),
		.t1_o(t1_val),
		.t2_o(t2_val),
		.underflow_o(t2_underflow)
	);

	// power state transitions
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (stop_instruction)
					next_state = ST_STOP;
				else if (wait_instruction)
					next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (irq_i)
					next_state = ST_RUN;
			end
			ST_STOP: begin
				if (irq_i)
					next_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (t2_underflow)
					next_state = ST_RUN;
			end
			default: next_state = ST_RUN;
		endcase
	end

	// state, pin capture and all software writable registers
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			state <= ST_RUN;
			sel_high <= 1'b0;
			init_pending <= 1'b1;
			cpu_mode_reg <= `CSC_MODE_RST_LO;
			cpu_mode_reg_second <= `CSC_MODE2_RST;
			t1_latch <= `CSC_T1_RST;
			t2_latch <= `CSC_T2_RST;
			t12_mode <= 8'h00;
			t12_divsel <= 8'h00;
		end else if (ce_i) begin
			state <= next_state;
			// pin level caught on the first edge after reset release
			if (init_pending) begin
				init_pending <= 1'b0;
				sel_high <= osc_select_pin_i;
				cpu_mode_reg <= forced_mode(osc_select_pin_i, cpu_mode_reg);
				cpu_mode_reg_second <= `CSC_MODE2_RST;
				cpu_mode_reg_second[`CSC_MODE2_ONCHIP_BIT] <= onchip_stop(osc_select_pin_i);
			end else if (stop_instruction) begin
				sel_high <= osc_select_pin_i;
				t12_mode <= t12_mode & `CSC_T12_STOP_MASK;
				// main and sub oscillators are killed while stopped
				cpu_mode_reg[`CSC_MODE_MAIN_BIT] <= 1'b1;
				cpu_mode_reg[`CSC_MODE_SUB_BIT] <= 1'b0;
			end else if (state == ST_STOP && irq_i) begin
				cpu_mode_reg <= forced_mode(sel_high, cpu_mode_reg);
				cpu_mode_reg_second[`CSC_MODE2_ONCHIP_BIT] <= onchip_stop(sel_high);
			end else if (wr_i && state == ST_RUN) begin
				case (addr_i)
					`CSC_ADDR_MODE: cpu_mode_reg <= wdata_i;
					`CSC_ADDR_MODE2: cpu_mode_reg_second <= wdata_i;
					`CSC_ADDR_T1_LATCH: t1_latch <= wdata_i;
					`CSC_ADDR_T2_LATCH: t2_latch <= wdata_i;
					`CSC_ADDR_T12_MODE: t12_mode <= wdata_i;
					`CSC_ADDR_T12_DIVSEL: t12_divsel <= wdata_i;
					default: t12_divsel <= t12_divsel;
				endcase
			end
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			rdata_o <= 8'h00;
			if (rd_i) begin
				case (addr_i)
					`CSC_ADDR_MODE: rdata_o <= cpu_mode_reg;
					`CSC_ADDR_MODE2: rdata_o <= cpu_mode_reg_second;
					`CSC_ADDR_T1_LATCH: rdata_o <= t1_val;
					`CSC_ADDR_T2_LATCH: rdata_o <= t2_val;
					`CSC_ADDR_T12_MODE: rdata_o <= t12_mode;
					`CSC_ADDR_T12_DIVSEL: rdata_o <= t12_divsel;
					`CSC_ADDR_STATUS: rdata_o <= {5'h00, sel_high, state};
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// oscillator enables and gated system clock
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			sys_clk_phase_o <= 1'b1;
			sys_clk_en_o <= 1'b0;
			main_osc_en_o <= 1'b0;
			sub_osc_en_o <= 1'b0;
			onchip_osc_en_o <= 1'b1;
			power_state_o <= ST_RUN;
		end else if (ce_i) begin
			power_state_o <= next_state;
			// clock held high in wait, stop and settle
			sys_clk_en_o <= (next_state == ST_RUN);
			sys_clk_phase_o <= (next_state == ST_RUN) ? div_phase : 1'b1;
			if (next_state == ST_STOP) begin
				main_osc_en_o <= 1'b0;
				sub_osc_en_o <= 1'b0;
				onchip_osc_en_o <= 1'b0;
			end else if (next_state == ST_SETTLE) begin
				// restart only the oscillator the pin selects
				main_osc_en_o <= sel_high && (FLASH_VARIANT == 0);
				sub_osc_en_o <= 1'b0;
				onchip_osc_en_o <= !(sel_high && (FLASH_VARIANT == 0));
			end else begin
				// a set stop bit stops main osc in any non-main mode
				main_osc_en_o <= !cpu_mode_reg[`CSC_MODE_MAIN_BIT] ||
					(cpu_mode_reg[`CSC_MODE_CLKSEL_HI:`CSC_MODE_CLKSEL_LO]
					== `CSC_CLK_DIV8) ||
					(cpu_mode_reg[`CSC_MODE_CLKSEL_HI:`CSC_MODE_CLKSEL_LO]
					== `CSC_CLK_DIV2);
				sub_osc_en_o <= cpu_mode_reg[`CSC_MODE_SUB_BIT];
				if (cpu_mode_reg[`CSC_MODE_CLKSEL_HI:`CSC_MODE_CLKSEL_LO] ==
					`CSC_CLK_LOWSPEED && FLASH_VARIANT == 0)
					onchip_osc_en_o <= 1'b0;
				else
					onchip_osc_en_o <= !cpu_mode_reg_second[`CSC_MODE2_ONCHIP_BIT] ||
						(FLASH_VARIANT != 0 &&
						cpu_mode_reg[`CSC_MODE_CLKSEL_HI:`CSC_MODE_CLKSEL_LO] ==
						`CSC_CLK_ONCHIP);
			end
		end
	end
endmodule

// >>> inc/csc_defs.vh
// constants for the clock and standby control block
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH
// register indices on the plain port
`define CSC_ADDR_MODE 4'h0
`define CSC_ADDR_MODE2 4'h1
`define CSC_ADDR_T1_LATCH 4'h2
`define CSC_ADDR_T2_LATCH 4'h3
`define CSC_ADDR_T12_MODE 4'h4
`define CSC_ADDR_T12_DIVSEL 4'h5
`define CSC_ADDR_CMD 4'h6
`define CSC_ADDR_STATUS 4'h7
// cpu mode register fields
`define CSC_MODE_SUB_BIT 4
`define CSC_MODE_MAIN_BIT 5
`define CSC_MODE_B3 3
`define CSC_MODE_CLKSEL_LO 6
`define CSC_MODE_CLKSEL_HI 7
`define CSC_MODE2_ONCHIP_BIT 0
// clock select field values (bits 7:6)
`define CSC_CLK_LOWSPEED 2'h0
`define CSC_CLK_DIV2 2'h1
`define CSC_CLK_DIV8 2'h2
`define CSC_CLK_ONCHIP 2'h3
// reset values: flash / low osc-select image and high osc-select image
`define CSC_MODE_RST_LO 8'he0
`define CSC_MODE_RST_HI 8'h88
`define CSC_MODE2_RST 8'h00
// mode bits that survive a forced rewrite (4, 2, 1, 0)
`define CSC_MODE_KEEP_MASK 8'h17
// timer latch values after reset
`define CSC_T1_RST 8'hff
`define CSC_T2_RST 8'h01
// bits of timer 12 mode register kept on stop; all other bits are cleared
`define CSC_T12_STOP_MASK 8'hc0
// command register bits
`define CSC_CMD_STOP_BIT 0
`define CSC_CMD_WAIT_BIT 1
// divide ratios
`define CSC_DIV_ONCHIP 6'h20
`define CSC_DIV_SUB 6'h02
`define CSC_DIV_MAIN8 6'h08
`define CSC_DIV_MAIN4 6'h04
`define CSC_DIV_MAIN2 6'h02
// power states
`define CSC_ST_RUN 2'h0
`define CSC_ST_WAIT 2'h1
`define CSC_ST_STOP 2'h2
`define CSC_ST_SETTLE 2'h3
`endif

// >>> logic/csc_clk_div.v
// divider producing a one-cycle tick every ratio source edges
module csc_clk_div #(
	parameter W = 6
) (
	input wire sys_clk_i,
	input wire srst_i,
	input wire ce_i,
	input wire src_tick_i,
	input wire [W-1:0] ratio_i,
	output reg tick_o,
	output reg phase_o
);
	reg [W-1:0] cnt;
	// half the ratio toggles phase so the clock stays near 50 percent
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			cnt <= {W{1'b0}};
			tick_o <= 1'b0;
			phase_o <= 1'b1;
		end else if (ce_i) begin
			tick_o <= 1'b0;
			if (src_tick_i) begin
				if (cnt >= ratio_i - {{(W-1){1'b0}}, 1'b1}) begin
					cnt <= {W{1'b0}};
					tick_o <= 1'b1;
					phase_o <= 1'b1;
				end else begin
					cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
					if (cnt + {{(W-1){1'b0}}, 1'b1} == (ratio_i >> 1))
						phase_o <= 1'b0;
				end
			end
		end
	end
endmodule

// >>> logic/csc_stab_timer.v
// timer 1 / timer 2 cascade used as stabilisation countdown in stop
module csc_stab_timer (
	input wire sys_clk_i,
	input wire srst_i,
	input wire ce_i,
	input wire load_i,
	input wire run_i,
	input wire src_tick_i,
	input wire [7:0] t1_latch_i,
	input wire [7:0] t2_latch_i,
	output reg [7:0] t1_o,
	output reg [7:0] t2_o,
	output reg underflow_o
);
	// timer 1 underflow feeds timer 2 directly while running
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			t1_o <= 8'hff;
			t2_o <= 8'h01;
			underflow_o <= 1'b0;
		end else if (ce_i) begin
			underflow_o <= 1'b0;
			if (load_i) begin
				t1_o <= t1_latch_i;
				t2_o <= t2_latch_i;
			end else if (run_i && src_tick_i) begin
				if (t1_o == 8'h00) begin
					t1_o <= t1_latch_i;
					if (t2_o == 8'h00) begin
						t2_o <= t2_latch_i;
						underflow_o <= 1'b1;
					end else begin
						t2_o <= t2_o - 8'h01;
					end
				end else begin
					t1_o <= t1_o - 8'h01;
				end
			end
		end
	end
endmodule

// >>> test/csc_osc_model.sv
// oscillator sources for the block: each ticks only while enabled
module csc_osc_model #(
	parameter int MAIN_P = 2,
	parameter int SUB_P = 8
) (
	input wire logic clk_i,
	input wire logic main_en_i,
	input wire logic sub_en_i,
	input wire logic onchip_en_i,
	output logic main_tick_o = 1'b0,
	output logic sub_tick_o = 1'b0,
	output logic onchip_tick_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cm = 0;
	int cs = 0;
	// a halted oscillator makes no edges, so its tick rests low
	always @(posedge clk_i) begin
		cm <= main_en_i ? (cm + 1) % MAIN_P : 0;
		cs <= sub_en_i ? (cs + 1) % SUB_P : 0;
		main_tick_o <= main_en_i && cm == MAIN_P - 1;
		sub_tick_o <= sub_en_i && cs == SUB_P - 1;
		onchip_tick_o <= onchip_en_i;
	end
endmodule

// >>> test/csc_top_chk.sv
// port assertions for the clock and standby block
module csc_top_chk (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic irq_i,
	input wire logic [7:0] rdata_o,
	input wire logic sys_clk_phase_o,
	input wire logic sys_clk_en_o,
	input wire logic main_osc_en_o,
	input wire logic sub_osc_en_o,
	input wire logic onchip_osc_en_o,
	input wire logic [1:0] power_state_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// command writes only count while running
	sequence s_cmd_stop;
		power_state_o == 2'h0 && ce_i && wr_i && addr_i == 4'h6 && wdata_i == 8'h01;
	endsequence
	sequence s_cmd_wait;
		power_state_o == 2'h0 && ce_i && wr_i && addr_i == 4'h6 && wdata_i == 8'h02;
	endsequence
	sequence s_wake;
		power_state_o == 2'h2 && ce_i && irq_i;
	endsequence
	AST_STOP_ENTRY: assert property (s_cmd_stop |=> power_state_o == 2'h2
		&& !main_osc_en_o && !sub_osc_en_o && !sys_clk_en_o) else $error("stop entry");
	AST_STOP_OSC_OFF: assert property (power_state_o == 2'h2 |->
		!main_osc_en_o && !sub_osc_en_o) else $error("osc running in stop");
	AST_HALT_HIGH: assert property (power_state_o != 2'h0 |->
		sys_clk_phase_o && !sys_clk_en_o) else $error("clock not halted high");
	AST_WAIT_ENTRY: assert property (s_cmd_wait |=> power_state_o == 2'h1
		&& $stable({main_osc_en_o, sub_osc_en_o, onchip_osc_en_o})) else $error("wait entry");
	AST_WAIT_EXIT: assert property (power_state_o == 2'h1 && ce_i && irq_i |=>
		power_state_o == 2'h0 && sys_clk_en_o) else $error("wait exit late");
	AST_STOP_WAKE: assert property (s_wake |=> power_state_o == 2'h3)
		else $error("stop wake");
	AST_STOP_HOLD: assert property (power_state_o == 2'h2 && !irq_i |=>
		power_state_o == 2'h2) else $error("stop left without wake");
	AST_SETTLE_END: assert property ($rose(power_state_o == 2'h3) |->
		##[1:1000] power_state_o == 2'h0) else $error("settle too long");
	AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside slot");
endmodule
bind csc_top csc_top_chk u_csc_top_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .irq_i(irq_i),
	.rdata_o(rdata_o), .sys_clk_phase_o(sys_clk_phase_o), .sys_clk_en_o(sys_clk_en_o),
	.main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
	.onchip_osc_en_o(onchip_osc_en_o), .power_state_o(power_state_o));

// >>> test/csc_top_tb.sv
// self-checking bench for the clock and standby block
module csc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MP = 2;
	localparam int SP = 8;
	logic sys_clk_i = 0, srst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, irq_i = 0, pin = 0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o, m, l1, l2, dv;
	logic ph, cen, men, sen, oen, mtk, stk, otk, p;
	logic [1:0] pst;
	logic [7:0] modes [6] = '{8'hc0, 8'he0, 8'h80, 8'h48, 8'h40, 8'h30};
	int err_total = 0, n_compared = 0, cyc = 0, n = 0, seed = 32'hfbed5549;
	csc_top u_csc_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .osc_select_pin_i(pin),
		.main_osc_tick_i(mtk), .sub_osc_tick_i(stk), .onchip_osc_tick_i(otk), .irq_i(irq_i),
		.rdata_o(rdata_o), .sys_clk_phase_o(ph), .sys_clk_en_o(cen), .main_osc_en_o(men),
		.sub_osc_en_o(sen), .onchip_osc_en_o(oen), .power_state_o(pst));
	csc_osc_model #(.MAIN_P(MP), .SUB_P(SP)) u_csc_osc_model (.clk_i(sys_clk_i),
		.main_en_i(men), .sub_en_i(sen), .onchip_en_i(oen), .main_tick_o(mtk),
		.sub_tick_o(stk), .onchip_tick_o(otk));
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// a hang ends the run as a failure
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// expected system clock period in bench cycles
	function automatic logic [7:0] exp_per(input logic [7:0] md);
		case (md[7:6])
			2'h3: return 8'd32;
			2'h2: return 8'(8 * MP);
			2'h1: return 8'((md[3] ? 4 : 2) * MP);
			default: return 8'(2 * SP);
		endcase
	endfunction
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	task pulse_irq;
		@(posedge sys_clk_i);
		irq_i <= 1'b1;
		@(posedge sys_clk_i);
		irq_i <= 1'b0;
	endtask
	// one full period, rise to rise
	task meas;
		while (ph !== 1'b0) @(posedge sys_clk_i);
		while (ph !== 1'b1) @(posedge sys_clk_i);
		n = 0;
		while (ph !== 1'b0) begin @(posedge sys_clk_i); n++; end
		while (ph !== 1'b1) begin @(posedge sys_clk_i); n++; end
	endtask
	task tally_and_finish;
		if (err_total == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 2; i++) begin
			srst_i <= 1'b1;
			pin <= i[0];
			repeat (i ? 32 : 6) @(posedge sys_clk_i);
			srst_i <= 1'b0;
			repeat (2) @(posedge sys_clk_i);
			rd(4'h0, i ? 8'h88 : 8'he0);
			rd(4'h1, i ? 8'h01 : 8'h00);
		end
		rd(4'h8, 8'h00);
		wr(4'h1, 8'h00);
		// every clock source, then random picks among them
		for (int i = 0; i < 10; i++) begin
			m = i < 6 ? modes[i] : modes[($random(seed) & 32'h7fff) % 6];
			wr(4'h0, m);
			repeat (64) @(posedge sys_clk_i);
			meas();
			chk(8'(n), exp_per(m));
			chk({5'h0, men, sen, oen}, {5'h0, ~m[5] | ^m[7:6], m[4], |m[7:6]});
		end
		// stop with the select pin flipped after the instruction
		for (int k = 0; k < 4; k++) begin
			p = $random(seed);
			l1 = 8'(($random(seed) & 1) + 1);
			l2 = 8'(($random(seed) & 1) + 1);
			dv = $random(seed);
			wr(4'h0, 8'hc0);
			wr(4'h2, l1);
			wr(4'h3, l2);
			wr(4'h4, 8'hff);
			wr(4'h5, dv);
			pin <= p;
			wr(4'h6, 8'h01);
			pin <= ~p;
			#1 chk({6'h0, pst}, 8'h02);
			rd(4'h3, l2);
			rd(4'h4, 8'hc0);
			rd(4'h5, dv);
			pulse_irq();
			n = 0;
			while (pst !== 2'h0 && n < 1000) begin @(posedge sys_clk_i); n++; end
			#1 chk({6'h0, pst}, 8'h00);
			chk({6'h0, men, oen}, {6'h0, p, ~p});
			rd(4'h0, p ? 8'h88 : 8'he0);
			rd(4'h1, {7'h0, p});
		end
		// wait: a mode write in wait is dropped, wake is immediate
		wr(4'h0, 8'hc0);
		wr(4'h6, 8'h02);
		#1 chk({6'h0, pst}, 8'h01);
		wr(4'h0, 8'h40);
		pulse_irq();
		#1 chk({6'h0, pst, cen}, 8'h01);
		rd(4'h0, 8'hc0);
		tally_and_finish();
	end
endmodule
